//--- src/cpu_logic_self_test.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// RQ1 - Both cores driven by one deterministic pattern engine that also checks responses.
// RQ2 - The test is split into separately runnable intervals.
// RQ3 - A run covers all remaining intervals or a programmed count.
// RQ4 - Start resumes after the last interval or restarts from the first.
// RQ5 - The core under test stays isolated for the whole run.
// RQ6 - A failing comparison records its interval number for software.
// RQ7 - A programmable time-out counter bounds each run.
// RQ8 - Software sets clocks, interval count, time-out, then starts.
// RQ9 - Each run ends by resetting the processor; software reads status afterwards.
// RQ10 - Software keeps the test clock at or below half bus rate.
// RQ11 - Test clock is divided from the processor clock by a software ratio.
// RQ12 - Each interval takes a fixed number of test clock cycles.
// RQ13 - The controller's processor reset is logged in exception status bit five.
// RQ14 - Time-out expiry ends the run, flags failure, resets the processor.
// RQ15 - Completion and pass or fail flags survive the ending reset.
module cpu_logic_self_test #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic scan_enable,
    output logic isolate,
    output logic [W-1:0] scan_pattern,
    input wire logic [W-1:0] core_a_resp,
    input wire logic [W-1:0] core_b_resp,
    output logic cpu_reset,
    output logic irq
);

    stc_pkg::state_t state;
    logic ctl_restart;
    logic ctl_all;
    logic [4:0] intervals_cfg;
    logic [31:0] div;
    logic [31:0] timeout_cfg;
    logic done_flag;
    logic pass_flag;
    logic fail_flag;
    logic tmo_flag;
    logic busy;
    logic [4:0] fail_interval;
    logic [4:0] cur_interval;
    logic [stc_pkg::EV_W-1:0] irq_status;
    logic [stc_pkg::EV_W-1:0] irq_mask;
    logic exc_cpu_reset;
    logic [31:0] div_cnt;
    logic tick;
    logic [10:0] cyc_cnt;
    logic [4:0] run_cnt;
    logic [4:0] target;
    logic [31:0] tmo_cnt;
    logic [3:0] rst_cnt;
    logic mismatch;
    logic start;
    logic start_first;
    logic [4:0] start_iv;
    logic [4:0] remaining;
    logic stop;
    logic tmo_hit;
    logic rst_last;
    logic [stc_pkg::EV_W-1:0] events;

    assign start = wr && (addr == stc_pkg::ADDR_CTRL) && wdata[stc_pkg::CTRL_START] && (state == stc_pkg::S_IDLE);
    // A finished sequence cannot be continued, so it wraps to the first interval
    assign start_first = wdata[stc_pkg::CTRL_RESTART] || (cur_interval >= stc_pkg::MAX_INTERVALS); // RQ4
    assign start_iv = start_first ? 5'h00 : cur_interval; // RQ4
    assign remaining = stc_pkg::MAX_INTERVALS - start_iv;
    assign tmo_hit = (tmo_cnt == 32'h00000000);
    assign stop = (state == stc_pkg::S_RUN) && (tmo_hit || mismatch || (run_cnt == target)); // RQ14
    assign rst_last = (rst_cnt == stc_pkg::RESET_CYCLES - 4'h1);

    always_comb begin
        events = '0;
        if (stop) begin
            events[stc_pkg::EV_DONE] = 1'b1;
            events[stc_pkg::EV_FAIL] = tmo_hit || mismatch;
            events[stc_pkg::EV_TMO] = tmo_hit;
        end
    end

    bist_engine #(
        .W(W)
    ) u_engine (
        .clk(clk),
        .rst_n(rst_n),
        .load(start && start_first),
        .step(tick && (state == stc_pkg::S_RUN) && !(tmo_hit || (run_cnt == target))),
        .resp_a(core_a_resp),
        .resp_b(core_b_resp),
        .pattern(scan_pattern),
        .mismatch(mismatch)
    ); // RQ1

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_restart <= 1'b0;
            ctl_all <= 1'b0;
            intervals_cfg <= stc_pkg::INTERVALS_RESET;
            div <= stc_pkg::DIV_RESET;
            timeout_cfg <= stc_pkg::TIMEOUT_RESET;
            irq_mask <= '0;
        end else if (wr) begin
            unique case (addr)
                stc_pkg::ADDR_CTRL: begin
                    ctl_restart <= wdata[stc_pkg::CTRL_RESTART];
                    ctl_all <= wdata[stc_pkg::CTRL_ALL];
                end
                stc_pkg::ADDR_INTERVALS: intervals_cfg <= wdata[4:0];
                stc_pkg::ADDR_CLOCK_DIVIDER: div <= wdata; // RQ11
                stc_pkg::ADDR_TIMEOUT: timeout_cfg <= wdata; // RQ7
                stc_pkg::ADDR_IRQ_MASK: irq_mask <= wdata[stc_pkg::EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= stc_pkg::S_IDLE;
        end else begin
            unique case (state)
                stc_pkg::S_IDLE: begin
                    if (start) begin
                        state <= stc_pkg::S_RUN;
                    end
                end
                stc_pkg::S_RUN: begin
                    if (stop) begin
                        state <= stc_pkg::S_RESET; // RQ9
                    end
                end
                stc_pkg::S_RESET: begin
                    if (rst_last) begin
                        state <= stc_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // Test clock divider; the ratio floor is left to software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (state == stc_pkg::S_RUN && !stop) begin
            if (div_cnt >= div) begin
                div_cnt <= 32'h00000000; // RQ11 RQ10
                tick <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 32'h00000001;
                tick <= 1'b0;
            end
        end else begin
            div_cnt <= 32'h00000000;
            tick <= 1'b0;
        end
    end

    // Interval bookkeeping
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_interval <= 5'h00;
            run_cnt <= 5'h00;
            target <= 5'h00;
            cyc_cnt <= 11'h000;
        end else if (start) begin
            cur_interval <= start_iv;
            run_cnt <= 5'h00;
            cyc_cnt <= 11'h000;
            if (wdata[stc_pkg::CTRL_ALL] || intervals_cfg > remaining) begin
                target <= remaining; // RQ3
            end else begin
                target <= intervals_cfg; // RQ3 RQ8
            end
        end else if (state == stc_pkg::S_RUN && !stop && tick) begin
            if (cyc_cnt == stc_pkg::INTERVAL_CYCLES - 11'h001) begin
                cyc_cnt <= 11'h000; // RQ12
                cur_interval <= cur_interval + 5'h01; // RQ2
                run_cnt <= run_cnt + 5'h01;
            end else begin
                cyc_cnt <= cyc_cnt + 11'h001; // RQ12
            end
        end
    end

    // Time-out counter, loaded from the programmed period at start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmo_cnt <= 32'hFFFFFFFF;
        end else if (start) begin
            tmo_cnt <= timeout_cfg; // RQ7 RQ8
        end else if (state == stc_pkg::S_RUN && !tmo_hit) begin
            tmo_cnt <= tmo_cnt - 32'h00000001; // RQ7
        end
    end

    // Result flags live outside the processor reset, so they survive it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_flag <= 1'b0;
            pass_flag <= 1'b0;
            fail_flag <= 1'b0;
            tmo_flag <= 1'b0;
            busy <= 1'b0;
            fail_interval <= 5'h00;
        end else if (start) begin
            done_flag <= 1'b0;
            pass_flag <= 1'b0;
            fail_flag <= 1'b0;
            tmo_flag <= 1'b0;
            busy <= 1'b1;
        end else if (stop) begin
            busy <= 1'b0;
            done_flag <= 1'b1; // RQ15
            if (tmo_hit) begin
                tmo_flag <= 1'b1; // RQ14
                fail_flag <= 1'b1;
            end else if (mismatch) begin
                fail_flag <= 1'b1;
                fail_interval <= cur_interval; // RQ6
            end else begin
                pass_flag <= 1'b1; // RQ15
            end
        end
    end

    // Processor reset pulse and isolation, aligned with the sequencer state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_cnt <= 4'h0;
            cpu_reset <= 1'b0;
            isolate <= 1'b0;
            scan_enable <= 1'b0;
        end else begin
            rst_cnt <= (state == stc_pkg::S_RESET && !rst_last) ? rst_cnt + 4'h1 : 4'h0;
            unique case (state)
                stc_pkg::S_IDLE: begin
                    cpu_reset <= 1'b0;
                    isolate <= start; // RQ5
                    scan_enable <= start;
                end
                stc_pkg::S_RUN: begin
                    cpu_reset <= stop; // RQ9
                    isolate <= 1'b1; // RQ5
                    scan_enable <= !stop;
                end
                stc_pkg::S_RESET: begin
                    // Isolation holds until the core leaves reset
                    cpu_reset <= !rst_last; // RQ9
                    isolate <= !rst_last; // RQ5
                    scan_enable <= 1'b0;
                end
            endcase
        end
    end

    // Sticky bits; a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status <= '0;
            exc_cpu_reset <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (wr && addr == stc_pkg::ADDR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~wdata[stc_pkg::EV_W-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            if (stop) begin
                exc_cpu_reset <= 1'b1; // RQ13
            end else if (wr && addr == stc_pkg::ADDR_EXC_STATUS && wdata[stc_pkg::EXC_CPU_RESET]) begin
                exc_cpu_reset <= 1'b0;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read port; unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            unique case (addr)
                stc_pkg::ADDR_CTRL: rdata <= {29'h0, ctl_all, ctl_restart, 1'b0};
                stc_pkg::ADDR_INTERVALS: rdata <= {27'h0, intervals_cfg};
                stc_pkg::ADDR_CLOCK_DIVIDER: rdata <= div;
                stc_pkg::ADDR_TIMEOUT: rdata <= timeout_cfg;
                stc_pkg::ADDR_STATUS: rdata <= {27'h0, busy, tmo_flag, fail_flag, pass_flag, done_flag}; // RQ15
                stc_pkg::ADDR_FAIL_INTERVAL: rdata <= {27'h0, fail_interval}; // RQ6
                stc_pkg::ADDR_CUR_INTERVAL: rdata <= {27'h0, cur_interval};
                stc_pkg::ADDR_IRQ_STATUS: rdata <= {29'h0, irq_status};
                stc_pkg::ADDR_IRQ_MASK: rdata <= {29'h0, irq_mask};
                stc_pkg::ADDR_EXC_STATUS: rdata <= {26'h0, exc_cpu_reset, 5'h00}; // RQ13
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_stop;
        stop;
    endsequence

    sequence s_reset_pulse;
        cpu_reset [*8] ##1 !cpu_reset;
    endsequence

    property p_isolate;
        (state != stc_pkg::S_IDLE) == isolate && (state == stc_pkg::S_RUN) == scan_enable;
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolation not tied to run"); // RQ5

    property p_fail_rec;
        stop && mismatch && !tmo_hit |=> fail_flag && !pass_flag && fail_interval == $past(cur_interval);
    endproperty
    a_fail_rec: assert property (p_fail_rec) else $error("failing interval not recorded"); // RQ6

    property p_timeout;
        state == stc_pkg::S_RUN && tmo_hit |=> tmo_flag && fail_flag && state == stc_pkg::S_RESET;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out did not end the run"); // RQ14

    property p_reset_pulse;
        s_stop |=> s_reset_pulse;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("processor reset pulse wrong length"); // RQ9

    property p_cause;
        $rose(cpu_reset) |-> exc_cpu_reset;
    endproperty
    a_cause: assert property (p_cause) else $error("reset cause bit not set"); // RQ13

    property p_tick;
        tick && div != 32'h00000000 |=> !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("test clock faster than divider allows"); // RQ11

    property p_advance;
        state == stc_pkg::S_RUN && !stop && tick && cyc_cnt == stc_pkg::INTERVAL_CYCLES - 11'h001
            |=> cur_interval == $past(cur_interval) + 5'h01 && cyc_cnt == 11'h000;
    endproperty
    a_advance: assert property (p_advance) else $error("interval did not advance"); // RQ12

    property p_restart;
        start && wdata[stc_pkg::CTRL_RESTART] |=> cur_interval == 5'h00 && state == stc_pkg::S_RUN && busy;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not begin at first interval"); // RQ4

    property p_count;
        stop && !tmo_hit && !mismatch |-> run_cnt == target ##1 pass_flag && done_flag;
    endproperty
    a_count: assert property (p_count) else $error("pass without programmed interval count"); // RQ3

    property p_irq;
        (irq_status & irq_mask) != '0 |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked event did not raise interrupt");

endmodule

//--- src/stc_pkg.sv
package stc_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'hFFFFE100;
    localparam logic [31:0] ADDR_INTERVALS = 32'hFFFFE104;
    localparam logic [31:0] ADDR_CLOCK_DIVIDER = 32'hFFFFE108;
    localparam logic [31:0] ADDR_TIMEOUT = 32'hFFFFE10C;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFFE110;
    localparam logic [31:0] ADDR_FAIL_INTERVAL = 32'hFFFFE114;
    localparam logic [31:0] ADDR_CUR_INTERVAL = 32'hFFFFE118;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFFFFE11C;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFFE120;
    localparam logic [31:0] ADDR_EXC_STATUS = 32'hFFFFE124;

    // Control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_RESTART = 1;
    localparam int CTRL_ALL = 2;

    // Status fields
    localparam int ST_DONE = 0;
    localparam int ST_PASS = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_TMO = 3;
    localparam int ST_BUSY = 4;

    // Event bits, shared by interrupt status and mask
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_TMO = 2;
    localparam int EV_W = 3;

    // Reset cause bit in the exception status word
    localparam int EXC_CPU_RESET = 5;

    // Reset values
    localparam logic [31:0] DIV_RESET = 32'h00000001;
    localparam logic [31:0] TIMEOUT_RESET = 32'hFFFFFFFF;
    localparam logic [4:0] INTERVALS_RESET = 5'h18;

    // Test geometry and timing counts
    localparam logic [4:0] MAX_INTERVALS = 5'h18;
    localparam logic [10:0] INTERVAL_CYCLES = 11'h555;
    localparam logic [3:0] RESET_CYCLES = 4'h8;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_RESET} state_t;

endpackage

//--- src/bist_engine.sv
`timescale 1ns/1ps

// Pattern source and response checker shared by both cores
module bist_engine #(
    parameter int W = 32,
    parameter logic [31:0] TAPS = 32'h80200003,
    parameter logic [31:0] SEED = 32'h00000001
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic step,
    input wire logic [W-1:0] resp_a,
    input wire logic [W-1:0] resp_b,
    output logic [W-1:0] pattern,
    output logic mismatch
);

    // Reseeding on every restart keeps the sequence deterministic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pattern <= SEED[W-1:0];
        end else if (load) begin
            pattern <= SEED[W-1:0];
        end else if (step) begin
            pattern <= {pattern[W-2:0], ^(pattern & TAPS[W-1:0])};
        end
    end

    // Both cores see the same stimulus, so any difference is a fault
    assign mismatch = step && (resp_a != resp_b);

endmodule

//--- bench/lockstep_cores.sv
`timescale 1ns/1ps

// While scan is enabled both cores answer the same function of the pattern; core B can be made to disagree
module lockstep_cores #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scan_enable,
    input wire logic [W-1:0] scan_pattern,
    input wire logic inject,
    output logic [W-1:0] core_a_resp,
    output logic [W-1:0] core_b_resp
);
    logic [W-1:0] idle_val;
    logic [W-1:0] resp;

    // Outside a run the outputs churn, so a stale compare cannot pass by luck
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_val <= '0;
        end else begin
            idle_val <= ~idle_val ^ scan_pattern;
        end
    end

    assign resp = {scan_pattern[W-2:0], scan_pattern[W-1]} ^ W'(32'h5A3C96E1);
    assign core_a_resp = scan_enable ? resp : idle_val;
    assign core_b_resp = scan_enable ? (resp ^ W'(inject)) : ~idle_val;
endmodule

//--- bench/cpu_logic_self_test_bench.sv
`timescale 1ns/1ps

module cpu_logic_self_test_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic inject = 1'b0;
    logic [31:0] addr = 32'h00000000;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] lf = 32'h00009A98;
    logic [31:0] rdata;
    logic [31:0] v;
    logic scan_enable;
    logic isolate;
    logic cpu_reset;
    logic irq;
    logic [31:0] scan_pattern;
    logic [31:0] core_a_resp;
    logic [31:0] core_b_resp;
    int n_errors = 0;
    int n_compared = 0;
    int se;
    int rs;

    always #50 clk = ~clk;

    cpu_logic_self_test uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .scan_enable(scan_enable), .isolate(isolate), .scan_pattern(scan_pattern),
        .core_a_resp(core_a_resp), .core_b_resp(core_b_resp), .cpu_reset(cpu_reset), .irq(irq));

    lockstep_cores cores (.clk(clk), .rst_n(rst_n), .scan_enable(scan_enable), .scan_pattern(scan_pattern),
        .inject(inject), .core_a_resp(core_a_resp), .core_b_resp(core_b_resp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Divider 1: one tick every two clocks
    function automatic int run_len(input int n);
        return 1365 * n * 2;
    endfunction

    function automatic logic [31:0] status_of(input logic p, input logic t);
        status_of = 32'h00000000;
        status_of[stc_pkg::ST_DONE] = 1'b1;
        status_of[stc_pkg::ST_PASS] = p;
        status_of[stc_pkg::ST_FAIL] = ~p;
        status_of[stc_pkg::ST_TMO] = t;
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Few cycles of slack for the start and stop handshakes
    task automatic check_se(input int lo);
        n_compared++;
        if (se < lo || se > lo + 3) begin
            n_errors++;
            $display("[FAIL] run cycles expected %0d seen %0d", lo, se);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(nm, e, rdata);
    endtask

    task automatic run(input logic [31:0] c);
        se = 0;
        rs = 0;
        wr_reg(stc_pkg::ADDR_CTRL, c);
        for (int i = 0; i < 80000; i++) begin
            #1;
            if (cpu_reset === 1'b1) break;
            if (scan_enable === 1'b1) se++;
            check("isolate in run", 1, isolate);
            @(posedge clk);
        end
        while (cpu_reset === 1'b1 && rs < 20) begin
            check("isolate in reset", 1, isolate);
            rs++;
            @(posedge clk);
            #1;
        end
        check("reset length", stc_pkg::RESET_CYCLES, rs);
        check("isolate after", 0, isolate);
    endtask

    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check("pattern seed", 32'h00000001, scan_pattern);
        rd_chk("divider", stc_pkg::ADDR_CLOCK_DIVIDER, stc_pkg::DIV_RESET);
        rd_chk("timeout", stc_pkg::ADDR_TIMEOUT, stc_pkg::TIMEOUT_RESET);
        rd_chk("intervals", stc_pkg::ADDR_INTERVALS, {27'h0, stc_pkg::INTERVALS_RESET});
        rd_chk("status", stc_pkg::ADDR_STATUS, 0);
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            wr_reg(stc_pkg::ADDR_CLOCK_DIVIDER, lf);
            rd_chk("divider rw", stc_pkg::ADDR_CLOCK_DIVIDER, lf);
            wr_reg(32'hFFFFE200, lf);
            rd_chk("unmapped", 32'hFFFFE200, 0);
            wr_reg(stc_pkg::ADDR_STATUS, lf);
            rd_chk("status ro", stc_pkg::ADDR_STATUS, 0);
        end
        // Half-rate test clock, then interval count, then time-out, then start
        wr_reg(stc_pkg::ADDR_CLOCK_DIVIDER, 1);
        wr_reg(stc_pkg::ADDR_INTERVALS, 2);
        wr_reg(stc_pkg::ADDR_TIMEOUT, 32'hFFFFFFFF);
        run(32'h3);
        check_se(run_len(2));
        rd_chk("cur after restart", stc_pkg::ADDR_CUR_INTERVAL, 2);
        rd_chk("status pass", stc_pkg::ADDR_STATUS, status_of(1, 0));
        rd_chk("exc cause", stc_pkg::ADDR_EXC_STATUS, 32'h20);
        wr_reg(stc_pkg::ADDR_EXC_STATUS, 32'h20);
        rd_chk("exc cleared", stc_pkg::ADDR_EXC_STATUS, 0);
        check("irq masked", 0, irq);
        wr_reg(stc_pkg::ADDR_IRQ_MASK, 1 << stc_pkg::EV_DONE);
        rd_chk("irq status", stc_pkg::ADDR_IRQ_STATUS, 1 << stc_pkg::EV_DONE);
        check("irq raised", 1, irq);
        wr_reg(stc_pkg::ADDR_IRQ_STATUS, 1 << stc_pkg::EV_DONE);
        rd_chk("irq cleared", stc_pkg::ADDR_IRQ_STATUS, 0);
        check("irq low", 0, irq);
        wr_reg(stc_pkg::ADDR_INTERVALS, 1);
        run(32'h1);
        check_se(run_len(1));
        rd_chk("cur continue", stc_pkg::ADDR_CUR_INTERVAL, 3);
        wr_reg(stc_pkg::ADDR_INTERVALS, 0);
        run(32'h1);
        check_se(0);
        rd_chk("cur zero count", stc_pkg::ADDR_CUR_INTERVAL, 3);
        // Core B disagrees from the first tick of interval three
        wr_reg(stc_pkg::ADDR_IRQ_MASK, 1 << stc_pkg::EV_FAIL);
        wr_reg(stc_pkg::ADDR_INTERVALS, 3);
        inject <= 1'b1;
        run(32'h1);
        inject <= 1'b0;
        check_se(2);
        rd_chk("fail interval", stc_pkg::ADDR_FAIL_INTERVAL, 3);
        rd_chk("status fail", stc_pkg::ADDR_STATUS, status_of(0, 0));
        check("irq on fail", 1, irq);
        rd_chk("irq fail", stc_pkg::ADDR_IRQ_STATUS, 32'h3);
        wr_reg(stc_pkg::ADDR_IRQ_STATUS, 32'h3);
        wr_reg(stc_pkg::ADDR_TIMEOUT, 50);
        wr_reg(stc_pkg::ADDR_INTERVALS, 1);
        run(32'h3);
        check_se(50);
        rd_chk("status timeout", stc_pkg::ADDR_STATUS, status_of(0, 1));
        rd_chk("irq timeout", stc_pkg::ADDR_IRQ_STATUS, 32'h7);
        rd_chk("exc timeout", stc_pkg::ADDR_EXC_STATUS, 32'h20);
        wr_reg(stc_pkg::ADDR_TIMEOUT, 32'hFFFFFFFF);
        run(32'h7);
        check_se(run_len(24));
        rd_chk("cur all", stc_pkg::ADDR_CUR_INTERVAL, 24);
        wr_reg(stc_pkg::ADDR_INTERVALS, 0);
        run(32'h1);
        rd_chk("cur wrap", stc_pkg::ADDR_CUR_INTERVAL, 0);
        finish_test;
    end
endmodule
